// ===== include/scsp_pkg.sv
// constants and types for the two-channel supply status and protection block
// assumes one 125 MHz clock and a command decoder outside that issues one-cycle strobes
// Behaviour
// - each of the two channels has its own status register with limit and thermal events.
// - status bit 0 of a channel is high while that channel sits at its current limit.
// - bit 0 falls by itself as soon as the over-current ends, it is never latched.
// - bit 1 catches any over-current and holds until the status clear command.
// - bit 4 catches a thermal event on the channel and holds until the status clear command.
// - a thermal event turns off every LED and every output relay of both channels.
// - after a thermal shutdown the module stays off until software issues the clear.
// - the clear command wipes all latched bits and re-enables the channels after a shutdown.
// - a status query returns the register byte, e.g. 0x03, 0x02 or 0x10.
// - a load-current query returns the selected channel's measured current in mA.
// - a voltage query returns the selected channel's sense-line voltage.
// - a channel at its current limit lights its LED red besides setting the flags.
// - a channel with signal generation disabled ignores triggers in measurement mode.
package scsp_pkg;
    localparam int NUM_CHANNELS      = 2;
    localparam int STATUS_WIDTH      = 8;
    localparam int BIT_LIVE_OC       = 0;
    localparam int BIT_LATCHED_OC    = 1;
    localparam int BIT_LATCHED_THERM = 4;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int CUR_WIDTH         = 16;
    localparam int VOLT_WIDTH        = 24;

    typedef enum logic [1:0] {
        QRY_STATUS,
        QRY_CURRENT,
        QRY_VOLTAGE,
        QRY_SIG_GEN
    } scsp_query_t;
endpackage : scsp_pkg

// ===== core/scsp_status_protect.sv
// status, protection and readback for a two-channel supply module
// assumes pin-level limit/thermal flags and measurement words arrive unsynchronised
`timescale 1ns/1ps
module scsp_word_sync #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] wordIn,
    output logic      [W-1:0] wordOut
);
    if (W < 1) begin : g_bad_width
        $error("word width must be at least 1");
    end

    // two flops, then a third to compare; only a word read alike twice is taken,
    // so a word caught mid-change never reaches a reply
    logic [W-1:0] stA_reg, stA_next;
    logic [W-1:0] stB_reg, stB_next;
    logic [W-1:0] stC_reg, stC_next;
    logic [W-1:0] hold_reg, hold_next;

    always_comb begin
        stA_next  = wordIn;
        stB_next  = stA_reg;
        stC_next  = stB_reg;
        hold_next = hold_reg;
        if (stB_reg == stC_reg) begin
            hold_next = stC_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stA_reg  <= '0;
            stB_reg  <= '0;
            stC_reg  <= '0;
            hold_reg <= '0;
        end else begin
            stA_reg  <= stA_next;
            stB_reg  <= stB_next;
            stC_reg  <= stC_next;
            hold_reg <= hold_next;
        end
    end

    assign wordOut = hold_reg;
endmodule : scsp_word_sync

module scsp_chan_status (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         atLimit,
    input  wire logic                         thermal,
    input  wire logic                         clear,
    output logic                              latchedThermal,
    output logic [scsp_pkg::STATUS_WIDTH-1:0] statusByte
);
    logic latOc_reg, latOc_next;
    logic latTh_reg, latTh_next;

    // set beats clear so an event in the clear cycle is kept
    always_comb begin
        latOc_next = latOc_reg;
        latTh_next = latTh_reg;
        if (clear) begin
            latOc_next = 1'b0;
            latTh_next = 1'b0;
        end
        latOc_next = latOc_next | atLimit;
        latTh_next = latTh_next | thermal;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latOc_reg <= 1'b0;
            latTh_reg <= 1'b0;
        end else begin
            latOc_reg <= latOc_next;
            latTh_reg <= latTh_next;
        end
    end

    // unused bits stay at their reset value, whatever the clear does
    always_comb begin
        statusByte = scsp_pkg::STATUS_RESET;
        statusByte[scsp_pkg::BIT_LIVE_OC]       = atLimit;
        statusByte[scsp_pkg::BIT_LATCHED_OC]    = latOc_reg;
        statusByte[scsp_pkg::BIT_LATCHED_THERM] = latTh_reg;
    end

    assign latchedThermal = latTh_reg;
endmodule : scsp_chan_status

module scsp_status_protect #(
    parameter int CUR_W  = scsp_pkg::CUR_WIDTH,
    parameter int VOLT_W = scsp_pkg::VOLT_WIDTH
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic [1:0]          atLimitPin,
    input  wire logic [1:0]          thermalPin,
    input  wire logic [CUR_W-1:0]    loadCurrent0,
    input  wire logic [CUR_W-1:0]    loadCurrent1,
    input  wire logic [VOLT_W-1:0]   senseVoltage0,
    input  wire logic [VOLT_W-1:0]   senseVoltage1,
    input  wire logic                channelSelect,
    input  wire logic                latchedStatusClearCmd,
    input  wire logic                signalGenEnableCmd,
    input  wire logic                signalGenEnableValue,
    input  wire logic                measurementMode,
    input  wire logic [1:0]          triggerIn,
    input  wire logic                queryValid,
    input  wire scsp_pkg::scsp_query_t queryKind,
    output logic                     answerValid,
    output logic [31:0]              answerData,
    output logic [1:0]               ledRed,
    output logic [1:0]               ledOn,
    output logic [1:0]               relayOn,
    output logic [1:0]               triggerOut,
    output logic                     moduleDisabled
);
    localparam int NCH = scsp_pkg::NUM_CHANNELS;

    // replies are 32 bits wide, so a wider measurement cannot be served
    if (CUR_W < 1 || CUR_W > 32 || VOLT_W < 1 || VOLT_W > 32) begin : g_bad_width
        $error("measurement width must be 1..32");
    end
    if (NCH != 2) begin : g_bad_count
        $error("pin groups are built for two channels");
    end

    // two-flop synchronisers for the pin flags; no filter, to keep the short lag
    logic [1:0] limA_reg, limA_next, limB_reg, limB_next;
    logic [1:0] thA_reg, thA_next, thB_reg, thB_next;

    always_comb begin
        limA_next = atLimitPin;
        limB_next = limA_reg;
        thA_next  = thermalPin;
        thB_next  = thA_reg;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            limA_reg <= '0;
            limB_reg <= '0;
            thA_reg  <= '0;
            thB_reg  <= '0;
        end else begin
            limA_reg <= limA_next;
            limB_reg <= limB_next;
            thA_reg  <= thA_next;
            thB_reg  <= thB_next;
        end
    end

    // measurement words, each taken only once it reads alike twice
    logic [CUR_W-1:0]  cur0, cur1;
    logic [VOLT_W-1:0] volt0, volt1;

    scsp_word_sync #(
        .W(CUR_W)
    ) cur0_u (
        .clk     (clk),
        .resetn  (resetn),
        .wordIn  (loadCurrent0),
        .wordOut (cur0)
    );

    scsp_word_sync #(
        .W(CUR_W)
    ) cur1_u (
        .clk     (clk),
        .resetn  (resetn),
        .wordIn  (loadCurrent1),
        .wordOut (cur1)
    );

    scsp_word_sync #(
        .W(VOLT_W)
    ) volt0_u (
        .clk     (clk),
        .resetn  (resetn),
        .wordIn  (senseVoltage0),
        .wordOut (volt0)
    );

    scsp_word_sync #(
        .W(VOLT_W)
    ) volt1_u (
        .clk     (clk),
        .resetn  (resetn),
        .wordIn  (senseVoltage1),
        .wordOut (volt1)
    );

    // status state: one latch pair per channel, live bit from the synchronised level
    logic [1:0]                        latTh;
    logic [scsp_pkg::STATUS_WIDTH-1:0] status [NCH];

    for (genvar g = 0; g < NCH; g++) begin : g_chan
        scsp_chan_status chan_u (
            .clk            (clk),
            .resetn         (resetn),
            .atLimit        (limB_reg[g]),
            .thermal        (thB_reg[g]),
            .clear          (latchedStatusClearCmd),
            .latchedThermal (latTh[g]),
            .statusByte     (status[g])
        );
    end

    logic [1:0] sigGen_reg, sigGen_next;

    always_comb begin
        sigGen_next = sigGen_reg;
        if (signalGenEnableCmd) begin
            sigGen_next[channelSelect] = signalGenEnableValue;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sigGen_reg <= '0;
        end else begin
            sigGen_reg <= sigGen_next;
        end
    end

    // shutdown holds while any thermal latch stands, covering both channels
    logic shutdown;
    assign shutdown = |latTh;

    // output drive state
    logic [1:0] ledRed_reg, ledRed_next, ledOn_reg, ledOn_next;
    logic [1:0] relay_reg, relay_next, trig_reg, trig_next;
    logic       dis_reg, dis_next;

    always_comb begin
        dis_next    = shutdown | (|thB_reg);
        ledOn_next  = dis_next ? 2'h0 : 2'h3;
        relay_next  = dis_next ? 2'h0 : 2'h3;
        ledRed_next = dis_next ? 2'h0 : limB_reg;
        trig_next   = '0;
        if (!dis_next) begin
            trig_next = measurementMode ? (triggerIn & sigGen_reg) : triggerIn;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ledRed_reg <= '0;
            ledOn_reg  <= '0;
            relay_reg  <= '0;
            trig_reg   <= '0;
            dis_reg    <= 1'b0;
        end else begin
            ledRed_reg <= ledRed_next;
            ledOn_reg  <= ledOn_next;
            relay_reg  <= relay_next;
            trig_reg   <= trig_next;
            dis_reg    <= dis_next;
        end
    end

    assign ledRed         = ledRed_reg;
    assign ledOn          = ledOn_reg;
    assign relayOn        = relay_reg;
    assign triggerOut     = trig_reg;
    assign moduleDisabled = dis_reg;

    // query answers, registered one cycle after the request
    logic        ansV_reg, ansV_next;
    logic [31:0] ansD_reg, ansD_next;

    always_comb begin
        ansV_next = queryValid;
        ansD_next = ansD_reg;
        if (queryValid) begin
            ansD_next = '0;
            case (queryKind)
                scsp_pkg::QRY_STATUS: begin
                    ansD_next[7:0] = status[channelSelect];
                end
                scsp_pkg::QRY_CURRENT: begin
                    ansD_next[CUR_W-1:0] = channelSelect ? cur1 : cur0;
                end
                scsp_pkg::QRY_VOLTAGE: begin
                    ansD_next[VOLT_W-1:0] = channelSelect ? volt1 : volt0;
                end
                default: begin
                    ansD_next[0] = sigGen_reg[channelSelect];
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ansV_reg <= 1'b0;
            ansD_reg <= '0;
        end else begin
            ansV_reg <= ansV_next;
            ansD_reg <= ansD_next;
        end
    end

    assign answerValid = ansV_reg;
    assign answerData  = ansD_reg;
endmodule : scsp_status_protect

// ===== testbench/scsp_status_protect_asserts.sv
// timing checks on the status, protection and readback ports
// assumes it is bound onto scsp_status_protect with its single clock
`timescale 1ns/1ps
module scsp_status_protect_asserts (
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic [1:0]            atLimitPin,
    input wire logic [1:0]            thermalPin,
    input wire logic                  latchedStatusClearCmd,
    input wire logic                  queryValid,
    input wire scsp_pkg::scsp_query_t queryKind,
    input wire logic                  answerValid,
    input wire logic [31:0]           answerData,
    input wire logic [1:0]            ledRed,
    input wire logic [1:0]            ledOn,
    input wire logic [1:0]            relayOn,
    input wire logic [1:0]            triggerOut,
    input wire logic                  moduleDisabled
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_answer_next: assert property (queryValid |=> answerValid)
        else $error("answer missing");
    chk_answer_only: assert property (answerValid |-> $past(queryValid))
        else $error("answer without query");
    chk_status_pad: assert property (answerValid && $past(queryKind) == scsp_pkg::QRY_STATUS
        |-> answerData[31:5] == 27'h0 && answerData[3:2] == 2'h0) else $error("unused bits set");
    chk_therm_off: assert property (moduleDisabled |-> ledOn == 2'h0 && relayOn == 2'h0)
        else $error("outputs on in shutdown");
    chk_therm_entry: assert property ((thermalPin != 2'h0)[*3] |=> moduleDisabled)
        else $error("shutdown late");
    // drop lags the clear by two cycles, so the clear cycle and the one after it are exempt
    chk_disable_hold: assert property (moduleDisabled && !latchedStatusClearCmd
        && !$past(latchedStatusClearCmd) |=> moduleDisabled) else $error("shutdown left early");
    chk_clear_enable: assert property (moduleDisabled && latchedStatusClearCmd
        && thermalPin == 2'h0 && $past(thermalPin) == 2'h0 && $past(thermalPin, 2) == 2'h0
        |-> ##[1:3] !moduleDisabled) else $error("clear did not re-enable");
    chk_red_limit: assert property ((atLimitPin[0] && !moduleDisabled
        && thermalPin == 2'h0)[*4] |-> ##[0:2] ledRed[0]) else $error("red led missing");
    chk_trig_off: assert property (moduleDisabled && $past(moduleDisabled)
        |-> triggerOut == 2'h0) else $error("trigger in shutdown");
endmodule : scsp_status_protect_asserts
bind scsp_status_protect scsp_status_protect_asserts chk_u (.clk(clk), .resetn(resetn),
    .atLimitPin(atLimitPin), .thermalPin(thermalPin), .queryValid(queryValid),
    .latchedStatusClearCmd(latchedStatusClearCmd), .queryKind(queryKind), .ledRed(ledRed),
    .answerValid(answerValid), .answerData(answerData), .ledOn(ledOn), .relayOn(relayOn),
    .triggerOut(triggerOut), .moduleDisabled(moduleDisabled));

// ===== testbench/scsp_status_protect_bench.sv
// directed bench for the supply status and protection block
// assumes the checker is bound separately; inputs change at the falling edge
`timescale 1ns/1ps
module scsp_status_protect_bench;
    logic                  clk = 1'b0, resetn = 1'b0, sel = 1'b0, clr = 1'b0;
    logic                  sgCmd = 1'b0, sgVal = 1'b0, meas = 1'b0, qv = 1'b0, av, dis;
    logic [1:0]            lim = 2'h0, th = 2'h0, trig = 2'h0, red, led, rly, tOut;
    logic [15:0]           cur0 = 16'h1234, cur1 = 16'h0ABC;
    logic [23:0]           sv0 = 24'h00A5C3, sv1 = 24'h3C5A00;
    logic [31:0]           ad;
    scsp_pkg::scsp_query_t qk = scsp_pkg::QRY_STATUS;
    int                    n_errors = 0, n_checks = 0;
    always #4 clk = ~clk;
    scsp_status_protect dut_u (.clk(clk), .resetn(resetn), .atLimitPin(lim), .thermalPin(th),
        .loadCurrent0(cur0), .loadCurrent1(cur1), .senseVoltage0(sv0), .senseVoltage1(sv1),
        .channelSelect(sel), .latchedStatusClearCmd(clr), .signalGenEnableCmd(sgCmd),
        .signalGenEnableValue(sgVal), .measurementMode(meas), .triggerIn(trig), .queryValid(qv),
        .queryKind(qk), .answerValid(av), .answerData(ad), .ledRed(red), .ledOn(led),
        .relayOn(rly), .triggerOut(tOut), .moduleDisabled(dis));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_n(int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    task automatic query(logic ch, scsp_pkg::scsp_query_t k, logic [31:0] exp, string what);
        sel = ch;
        qk = k;
        qv = 1'b1;
        wait_n(1);
        qv = 1'b0;
        check("answerValid", {31'h0, av}, 32'h1);
        check(what, ad, exp);
        wait_n(1);
    endtask : query
    task automatic pulse_clear;
        clr = 1'b1;
        wait_n(1);
        clr = 1'b0;
    endtask : pulse_clear
    task automatic test_limit;
        lim = 2'h1;
        wait_n(4);
        query(1'b0, scsp_pkg::QRY_STATUS, 32'h03, "status0");
        query(1'b1, scsp_pkg::QRY_STATUS, 32'h00, "status1");
        check("ledRed", {30'h0, red}, 32'h1);
        lim = 2'h0;
        wait_n(4);
        query(1'b0, scsp_pkg::QRY_STATUS, 32'h02, "status0");
        pulse_clear;
        wait_n(2);
        query(1'b0, scsp_pkg::QRY_STATUS, 32'h00, "status0");
        $display("test_limit done");
    endtask : test_limit
    task automatic test_thermal;
        th = 2'h2;
        wait_n(4);
        th = 2'h0;
        check("offs", {dis, 28'h0, led, 1'b0} | {30'h0, rly}, 32'h80000000);
        check("triggerOut", {30'h0, tOut}, 32'h0);
        query(1'b1, scsp_pkg::QRY_STATUS, 32'h10, "status1");
        query(1'b0, scsp_pkg::QRY_STATUS, 32'h00, "status0");
        wait_n(6);
        check("disabled", {31'h0, dis}, 32'h1);
        pulse_clear;
        wait_n(3);
        check("ledOn", {30'h0, led}, 32'h3);
        check("triggerOut", {30'h0, tOut}, 32'h3);
        query(1'b1, scsp_pkg::QRY_STATUS, 32'h00, "status1");
        $display("test_thermal done");
    endtask : test_thermal
    task automatic test_readback;
        query(1'b1, scsp_pkg::QRY_CURRENT, 32'h0ABC, "current1");
        query(1'b0, scsp_pkg::QRY_VOLTAGE, 32'hA5C3, "voltage0");
        query(1'b0, scsp_pkg::QRY_CURRENT, 32'h1234, "current0");
        query(1'b1, scsp_pkg::QRY_VOLTAGE, 32'h3C5A00, "voltage1");
        $display("test_readback done");
    endtask : test_readback
    task automatic test_trigger;
        meas = 1'b1;
        sel = 1'b0;
        sgCmd = 1'b1;
        wait_n(1);
        sel = 1'b1;
        sgVal = 1'b1;
        wait_n(1);
        sgCmd = 1'b0;
        query(1'b1, scsp_pkg::QRY_SIG_GEN, 32'h1, "sigGen1");
        trig = 2'h3;
        wait_n(2);
        check("triggerOut", {30'h0, tOut}, 32'h2);
        meas = 1'b0;
        wait_n(2);
        check("triggerOut", {30'h0, tOut}, 32'h3);
        $display("test_trigger done");
    endtask : test_trigger
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        wait_n(3);
        resetn = 1'b1;
        wait_n(1);
        check("relayOn", {30'h0, rly}, 32'h3);
        test_limit;
        test_readback;
        test_trigger;
        test_thermal;
        end_of_test;
    end
    // whole run is about 60 cycles
    initial begin
        #20000;
        n_errors++;
        end_of_test;
    end
endmodule : scsp_status_protect_bench
